// ==== pcq_cp_model.sv ====
// Control processor model writing instruction sets into the queue
`timescale 1ns/10ps

module pcq_cp_model import pcq_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              cpClkEn,
   input  wire logic              wrReady,
   output logic                   wrValid,
   output logic [WORD_W-1:0]      wrWord
);
   int nRefused = 0;
   int setGap   = 0;

   initial begin
      wrValid  = 1'b0;
      wrWord   = '0;
   end

   // ****************************************
   // Set writer, entered just after a rising edge
   // ****************************************
   task automatic send_set(input pcq_set_t s);
      logic [WORD_W-1:0] w [4];
      logic              rdy;
      w = '{s.cmdWord, s.srcWord, s.dstWord, s.lenWord};
      for (int i = 0; i < 4; i++) begin
         // Gated clock: nothing new is offered
         while (cpClkEn !== 1'b1) begin
            wrValid = 1'b0;
            @(posedge core_clk);
            #1;
         end
         wrValid = 1'b1;
         wrWord  = w[i];
         forever begin
            rdy = wrReady;
            @(posedge core_clk);
            if (rdy === 1'b1) break;
            nRefused++;
            #1;
         end
         #1;
      end
      wrValid = 1'b0;
      // Released bus shows a changed pattern, not the last word
      wrWord  = ~wrWord;
      // setGap + 1 idle edges (at least one) so a following set never re-drives in this step
      repeat (setGap + 1) @(posedge core_clk);
      #1;
   endtask
endmodule

// ==== pcq_pkg.sv ====
// Shared constants and types for the pipeline command queue
package pcq_pkg;
   localparam int WORD_W        = 24;
   localparam int SET_WORDS     = 4;
   localparam int QUEUE_ENTRIES = 64;
   localparam int SET_DEPTH     = QUEUE_ENTRIES / SET_WORDS;
   localparam int CODE_W        = 8;
   localparam int ADDR_W        = 16;
   localparam int CLK_PERIOD_NS = 5;
   localparam int PAC_TIME_NS   = 1920;
   localparam int PAC_CYCLES    = (PAC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PAC_READS     = 8;
   localparam int PAC_OUTPUTS   = 4;
   localparam int NEAR_FULL_FREE = 4;
   localparam logic [1:0] PARTIAL_RST = 2'h0;

   typedef struct packed {
      logic [WORD_W-1:0] lenWord;
      logic [WORD_W-1:0] dstWord;
      logic [WORD_W-1:0] srcWord;
      logic [WORD_W-1:0] cmdWord;
   } pcq_set_t;

   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [ADDR_W-1:0] srcAddr;
      logic [ADDR_W-1:0] dstAddr;
   } pcq_dec_t;

   typedef enum logic [1:0] {
      PCQ_IDLE   = 2'h0,
      PCQ_DECODE = 2'h1,
      PCQ_RUN    = 2'h3
   } pcq_state_t;
endpackage

// ==== pcq_top.sv ====
// Pipeline command queue: set FIFO, clock gating and pipeline command sequencer
// Behaviour
// - The queue holds at most 64 entries of 24 bits each.
// - Four consecutive words form one instruction set, so 16 sets fit.
// - Sets leave the queue through its own read pointer in arrival order.
// - Near full, the control processor clock is halted while the pipeline keeps draining.
// - Once drained below the threshold the control processor clock resumes.
// - With the queue empty and no command running the pipeline clock is stopped until a set arrives.
// - Each popped set is decoded into a command code and starting addresses.
// - Each command lasts 1.92 us and repeats until the whole block is covered.
// - The input address advances after every access until the block is done.
// - The pipeline runs on its own once a set is queued, reading and writing memory.
// - The command field selects one of up to 256 commands.
`timescale 1ns/10ps

// ****************************************
// Set FIFO
// ****************************************
module pcq_fifo #(
   parameter int WIDTH = 96,
   parameter int DEPTH = 16
) (
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     inValid,
   output logic                          inReady,
   input  wire logic [WIDTH-1:0]         inData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [WIDTH-1:0]              outData,
   output logic [$clog2(DEPTH+1)-1:0]    count
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    wrPtr_d;
   logic [PW-1:0]    rdPtr_q;
   logic [PW-1:0]    rdPtr_d;
   logic [CW-1:0]    count_q;
   logic [CW-1:0]    count_d;
   logic             push;
   logic             pop;
   assign inReady  = (count_q != CW'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
   assign count    = count_q;
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   always_comb begin
      wrPtr_d = push ? PW'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_d = pop ? PW'(rdPtr_q + 1'b1) : rdPtr_q;
      count_d = count_q;
      if (push && !pop) begin
         count_d = CW'(count_q + 1'b1);
      end else if (pop && !push) begin
         count_d = CW'(count_q - 1'b1);
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end
   a_ptr_order: assert property (@(posedge core_clk) disable iff (reset)
      PW'(wrPtr_q - rdPtr_q) == PW'(count_q))
      else $error("fifo pointers disagree with count");
endmodule
// ****************************************
// Queue top
// ****************************************
module pcq_top import pcq_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire logic              wrValid,
   output logic                   wrReady,
   input  wire logic [WORD_W-1:0] wrWord,
   output logic                   cpClkEn,
   output logic                   paClkEn,
   output logic                   paBusy,
   output pcq_dec_t               paCmd,
   output logic                   rdStrobe,
   output logic [ADDR_W-1:0]      rdAddr,
   output logic                   wrStrobe,
   output logic [ADDR_W-1:0]      wrAddr
);
   localparam int CNT_W = $clog2(SET_DEPTH+1);
   localparam int CYC_W = $clog2(PAC_CYCLES);
   localparam int ENT_W = $clog2(QUEUE_ENTRIES+1);
   // ****************************************
   // Set assembly
   // ****************************************
   logic [1:0]             partial_q;
   logic [1:0]             partial_d;
   logic [3*WORD_W-1:0]    hold_q;
   logic [3*WORD_W-1:0]    hold_d;
   logic                   wrAccept;
   logic                   setPush;
   logic                   setReady;
   logic                   setValid;
   logic                   setPop;
   pcq_set_t               setIn;
   pcq_set_t               setOut;
   logic [CNT_W-1:0]       setCount;
   logic [ENT_W-1:0]       entries;
   logic                   nearFull;
   assign setIn    = {wrWord, hold_q};
   assign setPush  = wrAccept && (partial_q == 2'h3);
   assign wrReady  = (partial_q != 2'h3) || setReady;
   assign wrAccept = wrValid && wrReady;
   assign entries  = ENT_W'({setCount, 2'h0}) + ENT_W'(partial_q);
   assign nearFull = entries > ENT_W'(QUEUE_ENTRIES - NEAR_FULL_FREE);
   assign cpClkEn  = !nearFull;
   always_comb begin
      partial_d = partial_q;
      hold_d    = hold_q;
      if (wrAccept) begin
         partial_d = 2'(partial_q + 1'b1);
         hold_d    = {wrWord, hold_q[3*WORD_W-1:WORD_W]};
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         partial_q <= PARTIAL_RST;
         hold_q    <= '0;
      end else begin
         partial_q <= partial_d;
         hold_q    <= hold_d;
      end
   end
   pcq_fifo #(
      .WIDTH ($bits(pcq_set_t)),
      .DEPTH (SET_DEPTH)
   ) u_fifo (
      .core_clk (core_clk),
      .reset    (reset),
      .inValid  (setPush),
      .inReady  (setReady),
      .inData   (setIn),
      .outValid (setValid),
      .outReady (setPop),
      .outData  (setOut),
      .count    (setCount)
   );
   // ****************************************
   // Pipeline sequencer
   // ****************************************
   pcq_state_t        st_q;
   pcq_state_t        st_d;
   pcq_dec_t          cmd_q;
   pcq_dec_t          cmd_d;
   logic [ADDR_W-1:0] remain_q;
   logic [ADDR_W-1:0] remain_d;
   logic [CYC_W-1:0]  cyc_q;
   logic [CYC_W-1:0]  cyc_d;
   logic [3:0]        beat_q;
   logic [3:0]        beat_d;
   logic              rdStrobe_q;
   logic              rdStrobe_d;
   logic [ADDR_W-1:0] rdAddr_q;
   logic [ADDR_W-1:0] rdAddr_d;
   logic              wrStrobe_q;
   logic              wrStrobe_d;
   logic [ADDR_W-1:0] wrAddr_q;
   logic [ADDR_W-1:0] wrAddr_d;
   assign setPop   = (st_q == PCQ_IDLE) && setValid;
   // A popped command is finished even if the queue runs dry meanwhile
   assign paClkEn  = (st_q != PCQ_IDLE) || setValid;
   assign paBusy   = (st_q != PCQ_IDLE);
   assign paCmd    = cmd_q;
   assign rdStrobe = rdStrobe_q;
   assign rdAddr   = rdAddr_q;
   assign wrStrobe = wrStrobe_q;
   assign wrAddr   = wrAddr_q;
   always_comb begin
      st_d       = st_q;
      cmd_d      = cmd_q;
      remain_d   = remain_q;
      cyc_d      = cyc_q;
      beat_d     = beat_q;
      rdStrobe_d = 1'b0;
      rdAddr_d   = rdAddr_q;
      wrStrobe_d = 1'b0;
      wrAddr_d   = wrAddr_q;
      unique case (st_q)
         PCQ_IDLE: begin
            if (setValid) begin
               cmd_d.code    = setOut.cmdWord[CODE_W-1:0];
               cmd_d.srcAddr = setOut.srcWord[ADDR_W-1:0];
               cmd_d.dstAddr = setOut.dstWord[ADDR_W-1:0];
               remain_d      = setOut.lenWord[ADDR_W-1:0];
               st_d          = PCQ_DECODE;
            end
         end
         PCQ_DECODE: begin
            cyc_d  = '0;
            beat_d = '0;
            st_d   = PCQ_RUN;
         end
         PCQ_RUN: begin
            cyc_d = CYC_W'(cyc_q + 1'b1);
            if ((beat_q < 4'(PAC_READS)) && (remain_q != '0)) begin
               rdStrobe_d    = 1'b1;
               rdAddr_d      = cmd_q.srcAddr;
               cmd_d.srcAddr = ADDR_W'(cmd_q.srcAddr + 1'b1);
               remain_d      = ADDR_W'(remain_q - 1'b1);
               beat_d        = 4'(beat_q + 1'b1);
            end
            if (cyc_q == CYC_W'(PAC_CYCLES - 1)) begin
               wrStrobe_d    = 1'b1;
               wrAddr_d      = cmd_q.dstAddr;
               cmd_d.dstAddr = ADDR_W'(cmd_q.dstAddr + ADDR_W'(PAC_OUTPUTS));
               cyc_d         = '0;
               beat_d        = '0;
               // Block covered: back to idle, otherwise the command repeats
               if (remain_d == '0) begin
                  st_d = PCQ_IDLE;
               end
            end
         end
         default: begin
            st_d = PCQ_IDLE;
         end
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q       <= PCQ_IDLE;
         cmd_q      <= '0;
         remain_q   <= '0;
         cyc_q      <= '0;
         beat_q     <= '0;
         rdStrobe_q <= 1'b0;
         rdAddr_q   <= '0;
         wrStrobe_q <= 1'b0;
         wrAddr_q   <= '0;
      end else begin
         st_q       <= st_d;
         cmd_q      <= cmd_d;
         remain_q   <= remain_d;
         cyc_q      <= cyc_d;
         beat_q     <= beat_d;
         rdStrobe_q <= rdStrobe_d;
         rdAddr_q   <= rdAddr_d;
         wrStrobe_q <= wrStrobe_d;
         wrAddr_q   <= wrAddr_d;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   localparam int PacLo = 385;
   localparam int PacHi = 385;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_entry_cap: assert property (entries <= ENT_W'(QUEUE_ENTRIES))
      else $error("queue holds more than its capacity");
   a_set_pairing: assert property (setPush |-> partial_q == 2'h3 ##1 partial_q == 2'h0)
      else $error("set pushed on a word other than the fourth");
   a_stall_full: assert property (nearFull |-> !cpClkEn && wrReady)
      else $error("control clock runs while queue near full");
   a_cp_resume: assert property ($fell(nearFull) |-> cpClkEn && $past(setPop))
      else $error("control clock not resumed after drain");
   a_pa_stop: assert property ((st_q == PCQ_IDLE && setCount == '0) |-> !paClkEn)
      else $error("pipeline clock runs with empty queue");
   a_pop_decode: assert property (setPop |=>
      cmd_q.code == $past(setOut.cmdWord[CODE_W-1:0])
      && remain_q == $past(setOut.lenWord[ADDR_W-1:0]))
      else $error("decoded command does not match popped set");
   a_pac_time: assert property (st_q == PCQ_DECODE |-> ##[PacLo:PacHi] wrStrobe_q)
      else $error("command period is not the expected length");
   a_addr_step: assert property (rdStrobe_q && $past(rdStrobe_q)
      |-> rdAddr_q == ADDR_W'($past(rdAddr_q) + 1'b1))
      else $error("input address did not advance by one");
   a_run_alone: assert property ((st_q == PCQ_RUN && cyc_q != CYC_W'(PAC_CYCLES - 1))
      |=> st_q == PCQ_RUN)
      else $error("pipeline left a command early");
   c_stall: cover property ($rose(nearFull) ##[1:1000] $fell(nearFull));
   c_wake: cover property (!paClkEn ##1 paClkEn ##1 st_q == PCQ_DECODE);
   c_repeat: cover property (wrStrobe_q && st_q == PCQ_RUN);
   c_full: cover property (setCount == CNT_W'(SET_DEPTH));
endmodule

// ==== pcq_top_tb_top.sv ====
// Self-checking testbench for the pipeline command queue
`timescale 1ns/10ps

module pcq_top_tb_top import pcq_pkg::*;;
   logic              core_clk;
   logic              reset;
   logic              wrValid;
   logic              wrReady;
   logic [WORD_W-1:0] wrWord;
   logic              cpClkEn;
   logic              paClkEn;
   logic              paBusy;
   pcq_dec_t          paCmd;
   logic              rdStrobe;
   logic [ADDR_W-1:0] rdAddr;
   logic              wrStrobe;
   logic [ADDR_W-1:0] wrAddr;
   int                n_mismatch;
   int                checks_done;
   int                cyc = 0;
   logic              sawStall = 1'b0;
   logic [ADDR_W-1:0] rdQ [$];
   logic [ADDR_W-1:0] wrQ [$];
   logic [CODE_W-1:0] codeQ [$];
   int                wrT [$];

   pcq_top uut (.core_clk(core_clk), .reset(reset), .wrValid(wrValid), .wrReady(wrReady),
      .wrWord(wrWord), .cpClkEn(cpClkEn), .paClkEn(paClkEn), .paBusy(paBusy), .paCmd(paCmd),
      .rdStrobe(rdStrobe), .rdAddr(rdAddr), .wrStrobe(wrStrobe), .wrAddr(wrAddr));

   pcq_cp_model cp (.core_clk(core_clk), .cpClkEn(cpClkEn), .wrReady(wrReady),
      .wrValid(wrValid), .wrWord(wrWord));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ****************************************
   // Output monitor
   // ****************************************
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (reset === 1'b0) begin
         if (rdStrobe === 1'b1) rdQ.push_back(rdAddr);
         if (wrStrobe === 1'b1) begin
            wrQ.push_back(wrAddr);
            codeQ.push_back(paCmd.code);
            wrT.push_back(cyc);
         end
         if (cpClkEn === 1'b0 && paClkEn === 1'b1) sawStall <= 1'b1;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_val(input string nm, input logic [ADDR_W-1:0] e,
                          input logic [ADDR_W-1:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wait_done(input int n);
      int k;
      for (k = 0; k < 20000 && (wrQ.size() < n || paClkEn !== 1'b0); k++) begin
         @(posedge core_clk);
         #1;
      end
      if (k == 20000) chk_bit("completion", 1'b1, 1'b0);
   endtask

   function automatic pcq_set_t mk(input logic [7:0] c, input logic [15:0] s, d, l);
      return '{lenWord: {8'h00, l}, dstWord: {8'h00, d}, srcWord: {8'h00, s},
               cmdWord: {16'h0000, c}};
   endfunction

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk_bit("cpClkEn", 1'b1, cpClkEn);
      chk_bit("paClkEn", 1'b0, paClkEn);
      chk_bit("paBusy", 1'b0, paBusy);
      chk_bit("wrReady", 1'b1, wrReady);
      chk_bit("rdStrobe", 1'b0, rdStrobe);
   endtask

   // Ten words need two commands: eight reads then two
   task automatic t_single;
      cp.setGap = 32;
      cp.send_set(mk(8'hA5, 16'h0100, 16'h0200, 16'h000A));
      chk_bit("paBusy", 1'b1, paBusy);
      chk_bit("paClkEn", 1'b1, paClkEn);
      wait_done(2);
      chk_val("reads", 16'h000A, ADDR_W'(rdQ.size()));
      foreach (rdQ[i]) chk_val("rdAddr", 16'h0100 + ADDR_W'(i), rdQ[i]);
      chk_val("wrAddr0", 16'h0200, wrQ[0]);
      chk_val("wrAddr1", 16'h0204, wrQ[1]);
      chk_val("code", 16'h00A5, {8'h00, codeQ[0]});
      chk_val("pacTime", ADDR_W'(PAC_CYCLES), ADDR_W'(wrT[1] - wrT[0]));
      chk_val("srcEnd", 16'h010A, paCmd.srcAddr);
      chk_val("dstEnd", 16'h0208, paCmd.dstAddr);
      chk_bit("paBusy", 1'b0, paBusy);
      chk_bit("paClkEn", 1'b0, paClkEn);
      rdQ.delete();
      wrQ.delete();
      codeQ.delete();
      cp.setGap = 0;
   endtask

   // Seventeen sets overrun the queue and must stall the writer
   task automatic t_fill;
      for (int i = 0; i < 17; i++)
         cp.send_set(mk(8'hFF - 8'(i), 16'h2000, 16'h1000 + 16'(i * 16), 16'h0000));
      wait_done(17);
      for (int i = 0; i < 17; i++) begin
         chk_val("setDst", 16'h1000 + 16'(i * 16), wrQ[i]);
         chk_val("setCode", {8'h00, 8'hFF - 8'(i)}, {8'h00, codeQ[i]});
      end
      chk_bit("stall", 1'b1, sawStall);
      chk_val("refused", 16'h0000, ADDR_W'(cp.nRefused));
      chk_bit("cpClkEn", 1'b1, cpClkEn);
      chk_bit("paClkEn", 1'b0, paClkEn);
      chk_val("reads", 16'h0000, ADDR_W'(rdQ.size()));
   endtask

   initial begin
      reset       = 1'b1;
      n_mismatch  = 0;
      checks_done = 0;
      repeat (6) @(posedge core_clk);
      #1;
      reset = 1'b0;
      t_reset();
      t_single();
      t_fill();
      test_done();
   end

   // Runs take under 9000 cycles
   initial begin
      #100000;
      chk_bit("watchdog", 1'b1, 1'b0);
      test_done();
   end
endmodule
